// ---- hw/sldrv_top.v ----
// Status LED driver: one LED register, condition combiner, pin stage.
// Assumes status inputs are asynchronous pins; soft reset/stop absent.
// Assumes a single-cycle register bus: one-cycle strobes, no wait states.
// Assumes the board pulls the pin up whenever the driver releases it.
// Functional notes
// - Polarity 0: pull pin low when indicator true, float otherwise.
// - Polarity 1: drive pin high when true, low when false.
// - Polarity changes only the pin; status bit stays true-high.
// - Disable bit 13 set keeps the pin undriven always.
// - Speed enable bit 12 shows 100 Mbps operation.
// - Bits 11 and 10 reserved: written zero, read zero.
// - Bit 9 shows wake frame detected while wake mode enabled.
// - Bit 8 shows link pass combined with full duplex.
// - Bit 7 enables stretching of each new event.
// - Bit 6 shows link pass state.
// - Bit 5 shows address-matched receive activity.
// - Bit 0 shows collision activity.
// - Hard reset clears enables; soft reset and stop leave them.
// - Hard reset sets stretch enable; soft reset and stop leave it.
// - Indicator is OR of enabled conditions and drives the pin.
// - Bit 15 reads unstretched indicator, read-only, reset-free.
// - LED register writes ignored while programming allow is clear.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sldrv_defines.vh"

module sldrv_top #(
   parameter                         STRETCH_W   = `SLDRV_STRETCH_W,
   parameter [STRETCH_W-1:0]         STRETCH_CYC = `SLDRV_STRETCH_CYC
) (
   input  wire                       i_sys_clk,
   input  wire                       i_nrst,
   input  wire [`SLDRV_ADDR_W-1:0]   i_addr,
   input  wire [31:0]                i_wdata,
   input  wire                       i_wr,
   input  wire                       i_rd,
   output reg  [31:0]                o_rdata,
   input  wire                       i_fast_speed,
   input  wire                       i_wake_mode,
   input  wire                       i_wake_frame,
   input  wire                       i_link_pass,
   input  wire                       i_full_duplex,
   input  wire                       i_matched_rx,
   input  wire                       i_rx_activity,
   input  wire                       i_collision,
   output wire                       o_led_out,
   output wire                       o_led_oe_n
);

   // ******************************
   // Pin synchronisers
   // ******************************
   reg  [7:0] sync1_q;
   reg  [7:0] sync2_q;
   wire [7:0] raw_in;

   assign raw_in = {i_fast_speed, i_wake_mode, i_wake_frame, i_link_pass,
                    i_full_duplex, i_matched_rx, i_rx_activity, i_collision};

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   wire s_fast;
   wire s_wmode;
   wire s_wframe;
   wire s_link;
   wire s_duplex;
   wire s_mrx;
   wire s_rx;
   wire s_col;

   // Second stage only; the first stage may still be metastable
   assign s_fast   = sync2_q[7];
   assign s_wmode  = sync2_q[6];
   assign s_wframe = sync2_q[5];
   assign s_link   = sync2_q[4];
   assign s_duplex = sync2_q[3];
   assign s_mrx    = sync2_q[2];
   assign s_rx     = sync2_q[1];
   assign s_col    = sync2_q[0];

   // ******************************
   // Registers
   // ******************************
   reg  [31:0] led_q;
   reg  [31:0] led_d;
   reg  [31:0] cfg_q;
   reg  [31:0] cfg_d;
   wire        prog_allow;
   wire        sel_led;
   wire        sel_cfg;
   wire        wr_led;
   wire        wr_cfg;
   wire        rd_led;
   wire        rd_cfg;

   // ******************************
   // Address decode
   // ******************************
   // Strobes decoded once so write and read paths agree on the map
   assign sel_led    = (i_addr == `SLDRV_ADDR_LED);
   assign sel_cfg    = (i_addr == `SLDRV_ADDR_CFG);
   assign wr_led     = i_wr & sel_led;
   assign wr_cfg     = i_wr & sel_cfg;
   assign rd_led     = i_rd & sel_led;
   assign rd_cfg     = i_rd & sel_cfg;
   assign prog_allow = cfg_q[`SLDRV_B_PROG_ALLOW];

   // ******************************
   // Register next state
   // ******************************
   // A locked LED word keeps its value; the cfg word is never locked
   always @* begin
      led_d = led_q;
      cfg_d = cfg_q;
      if (wr_led && prog_allow) begin
         led_d = i_wdata & `SLDRV_LED_WMASK;
      end
      if (wr_cfg) begin
         cfg_d = i_wdata & `SLDRV_CFG_WMASK;
      end
   end

   // Only i_nrst (hard reset) touches these; no soft reset or stop input
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         led_q <= `SLDRV_LED_RESET;
         cfg_q <= `SLDRV_CFG_RESET;
      end else begin
         led_q <= led_d;
         cfg_q <= cfg_d;
      end
   end

   // ******************************
   // Field decode
   // ******************************
   wire pol_sel;
   wire out_off;
   wire fast_show;
   wire wake_show;
   wire duplex_show;
   wire stretch_on;
   wire link_show;
   wire mrx_show;
   wire rx_show;
   wire col_show;

   assign pol_sel     = led_q[`SLDRV_B_POL];
   assign out_off     = led_q[`SLDRV_B_OFF];
   assign fast_show   = led_q[`SLDRV_B_FAST];
   assign wake_show   = led_q[`SLDRV_B_WAKE];
   assign duplex_show = led_q[`SLDRV_B_DUPLEX];
   assign stretch_on  = led_q[`SLDRV_B_STRETCH];
   assign link_show   = led_q[`SLDRV_B_LINK];
   assign mrx_show    = led_q[`SLDRV_B_MRX];
   assign rx_show     = led_q[`SLDRV_B_RX];
   assign col_show    = led_q[`SLDRV_B_COL];

   // ******************************
   // Condition combiner
   // ******************************
   wire term_fast;
   wire term_wake;
   wire term_duplex;
   wire term_link;
   wire term_mrx;
   wire term_rx;
   wire term_col;
   wire combined_indicator;

   assign term_fast   = fast_show & s_fast;
   assign term_wake   = wake_show & s_wmode & s_wframe;
   assign term_duplex = duplex_show & s_link & s_duplex;
   assign term_link   = link_show & s_link;
   assign term_mrx    = mrx_show & s_mrx;
   assign term_rx     = rx_show & s_rx;
   assign term_col    = col_show & s_col;

   // Bits 4, 3 and 1 have no source in this block and add nothing
   assign combined_indicator = term_fast | term_wake | term_duplex
                             | term_link | term_mrx | term_rx
                             | term_col;

   // ******************************
   // Stretcher
   // ******************************
   // Counter runs even with stretching off; only the mux ignores it
   wire stretched;

   sldrv_stretch #(
      .CNT_W  (STRETCH_W),
      .CYCLES (STRETCH_CYC)
   ) u_stretch (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_evt     (combined_indicator),
      .o_hold    (stretched)
   );

   // ******************************
   // Pin drive
   // ******************************
   reg  out_q;
   reg  out_d;
   reg  oe_n_q;
   reg  oe_n_d;
   wire lit;

   // Stretch applies to the pin only, so the status bit stays raw
   assign lit = stretch_on ? stretched : combined_indicator;

   // Open drain never drives high, so the data bit stays low there
   always @* begin
      out_d  = 1'b0;
      oe_n_d = 1'b1;
      if (out_off) begin
         out_d  = 1'b0;
         oe_n_d = 1'b1;
      end else if (pol_sel) begin
         out_d  = lit;
         oe_n_d = 1'b0;
      end else begin
         out_d  = 1'b0;
         oe_n_d = ~lit;
      end
   end

   // Registered pin stage avoids glitches from the combiner
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         out_q  <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         out_q  <= out_d;
         oe_n_q <= oe_n_d;
      end
   end

   // ******************************
   // Pin outputs
   // ******************************
   assign o_led_out  = out_q;
   assign o_led_oe_n = oe_n_q;

   // ******************************
   // Read port
   // ******************************
   reg  [31:0] led_view;
   reg  [31:0] rdata_d;

   // Built bit by bit so reserved and unused bits always read zero
   always @* begin
      led_view = 32'h0000_0000;
      // Status bit ignores polarity and stretch
      led_view[`SLDRV_B_COMBINED] = combined_indicator;
      led_view[`SLDRV_B_POL]      = pol_sel;
      led_view[`SLDRV_B_OFF]      = out_off;
      led_view[`SLDRV_B_FAST]     = fast_show;
      led_view[`SLDRV_B_WAKE]     = wake_show;
      led_view[`SLDRV_B_DUPLEX]   = duplex_show;
      led_view[`SLDRV_B_STRETCH]  = stretch_on;
      led_view[`SLDRV_B_LINK]     = link_show;
      led_view[`SLDRV_B_MRX]      = mrx_show;
      led_view[`SLDRV_B_RX]       = rx_show;
      led_view[`SLDRV_B_COL]      = col_show;
   end

   // Unmapped addresses and idle cycles both return zero
   always @* begin
      rdata_d = 32'h0000_0000;
      if (rd_led) begin
         rdata_d = led_view;
      end else if (rd_cfg) begin
         rdata_d = cfg_q;
      end
   end

   // ******************************
   // Read data register
   // ******************************
   // Data stands for one cycle only, then drops back to zero
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= 32'h0000_0000;
      end else begin
         o_rdata <= rdata_d;
      end
   end

endmodule // sldrv_top

`default_nettype wire

// ---- hw/sldrv_defines.vh ----
// Constants for the status LED driver: register layout, reset values.
// Assumes inclusion by bare name from design files under hw/.
`ifndef SLDRV_DEFINES_VH
`define SLDRV_DEFINES_VH

// ******************************
// Register map
// ******************************
`define SLDRV_ADDR_W          4
`define SLDRV_ADDR_LED        4'h0
`define SLDRV_ADDR_CFG        4'h4

// ******************************
// Field positions of led_status_control
// ******************************
`define SLDRV_B_COMBINED      15
`define SLDRV_B_POL           14
`define SLDRV_B_OFF           13
`define SLDRV_B_FAST          12
`define SLDRV_B_WAKE          9
`define SLDRV_B_DUPLEX        8
`define SLDRV_B_STRETCH       7
`define SLDRV_B_LINK          6
`define SLDRV_B_MRX           5
`define SLDRV_B_RX            2
`define SLDRV_B_COL           0
// Cfg register: indicator programming allow
`define SLDRV_B_PROG_ALLOW    12

// Writable bits of the LED register; reserved and read-only bits excluded
`define SLDRV_LED_WMASK       32'h0000_73e5
`define SLDRV_LED_RESET       32'h0000_0080
`define SLDRV_CFG_RESET       32'h0000_0000
// Cfg register: only the programming allow bit is kept
`define SLDRV_CFG_WMASK       32'h0000_1000

// ******************************
// Stretcher
// ******************************
`define SLDRV_STRETCH_CYC     20'h0_f424
`define SLDRV_STRETCH_W       20

`endif

// ---- hw/sldrv_stretch.v ----
// Pulse stretcher: restartable down-counter holding its output high.
// Assumes i_evt is synchronous to i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "sldrv_defines.vh"

module sldrv_stretch #(
   parameter CNT_W = `SLDRV_STRETCH_W,
   parameter [CNT_W-1:0] CYCLES = `SLDRV_STRETCH_CYC
) (
   input  wire i_sys_clk,
   input  wire i_nrst,
   input  wire i_evt,
   output wire o_hold
);

   reg             evt_q;
   reg [CNT_W-1:0] cnt_q;
   wire            new_evt;

   // Only a rising edge counts as a new occurrence
   assign new_evt = i_evt & ~evt_q;

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         evt_q <= 1'b0;
         cnt_q <= {CNT_W{1'b0}};
      end else begin
         evt_q <= i_evt;
         if (new_evt) begin
            cnt_q <= CYCLES;
         end else if (cnt_q != {CNT_W{1'b0}}) begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   assign o_hold = i_evt | (cnt_q != {CNT_W{1'b0}});

endmodule // sldrv_stretch

`default_nettype wire

// ---- tb/sldrv_led_model.sv ----
// External indicator LED on the driver's pin, with its pull-up.
// Assumes oe_n low means the driver owns the pin.
`timescale 1ns/1ps
`default_nettype none
module sldrv_led_model (
   input  wire logic i_led_out,
   input  wire logic i_led_oe_n,
   output wire logic o_pin
);
   // A released pin rests at the pull-up level, never at the old value
   assign o_pin = i_led_oe_n ? 1'b1 : i_led_out;
endmodule // sldrv_led_model
`default_nettype wire

// ---- tb/sldrv_chk_sva.sv ----
// Port checker for the status LED driver, bound to sldrv_top.
// Assumes one clock; keeps a shadow of software writes.
`timescale 1ns/1ps
`default_nettype none
module sldrv_chk (
   input wire logic        i_sys_clk,
   input wire logic        i_nrst,
   input wire logic [3:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        i_collision,
   input wire logic        o_led_out,
   input wire logic        o_led_oe_n
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   logic [15:0] sh_q;
   logic        alw_q;
   wire rd0  = i_rd && i_addr == 4'h0;
   wire dark = (sh_q & 16'h13e5) == 16'h0;
   wire odm  = !sh_q[14] && !sh_q[13];
   wire tpm  = sh_q[14] && !sh_q[13];
   // Shadow honours the write lock, so read-back checks see it too
   always_ff @(posedge i_sys_clk or negedge i_nrst)
      if (!i_nrst) begin
         sh_q  <= 16'h0080;
         alw_q <= 1'b0;
      end else if (i_wr && i_addr == 4'h4)
         alw_q <= i_wdata[12];
      else if (i_wr && i_addr == 4'h0 && alw_q)
         sh_q <= i_wdata[15:0] & 16'h73e5;
   a_reg_read: assert property (rd0 |=>
      o_rdata[14:0] == $past(sh_q[14:0])) else $error("led readback");
   a_ind_read: assert property
      ((sh_q[0] && i_collision)[*4] ##0 rd0 |=> o_rdata[15])
      else $error("indicator bit");
   a_off_float: assert property (sh_q[13][*3] |-> o_led_oe_n)
      else $error("pin driven while off");
   a_od_low: assert property ((!sh_q[14])[*3] |->
      o_led_oe_n || !o_led_out) else $error("open drain drove high");
   a_totem_drive: assert property (tpm[*3] |-> !o_led_oe_n)
      else $error("totem pin released");
   a_dark_od: assert property ((dark && odm)[*5] |-> o_led_oe_n)
      else $error("dark pin not floating");
   a_dark_totem: assert property ((dark && tpm)[*5] |-> !o_led_out)
      else $error("dark pin not low");
   a_lit_pin: assert property
      ((sh_q[0] && !sh_q[13] && i_collision && $stable(sh_q))[*5]
      |-> !o_led_oe_n && o_led_out == sh_q[14]) else $error("pin unlit");
   cover property (rd0 && sh_q[7]);
   cover property (sh_q[13] && i_collision);
   cover property (tpm && !o_led_oe_n && o_led_out);
endmodule // sldrv_chk
bind sldrv_top sldrv_chk u_sldrv_chk (.i_sys_clk, .i_nrst, .i_addr,
   .i_wdata, .i_wr, .i_rd, .o_rdata, .i_collision, .o_led_out, .o_led_oe_n);
`default_nettype wire

// ---- tb/sldrv_top_test.sv ----
// Register and pin tests for the status LED driver.
// Assumes the LED model on the pin; stretch shortened to 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module sldrv_top_test;
   logic        i_sys_clk = 1'b0;
   logic        i_nrst    = 1'b0;
   logic [3:0]  i_addr    = 4'h0;
   logic [31:0] i_wdata   = 32'h0;
   logic        i_wr      = 1'b0;
   logic        i_rd      = 1'b0;
   logic [7:0]  st        = 8'h0;
   logic [31:0] o_rdata;
   logic        o_led_out;
   logic        o_led_oe_n;
   logic        pin;
   int          num_errors = 0;
   int          compares   = 0;
   always #50 i_sys_clk = ~i_sys_clk;
   sldrv_top #(.STRETCH_CYC(20'h0_0008)) u_sldrv_top (.i_sys_clk, .i_nrst,
      .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_fast_speed(st[7]),
      .i_wake_mode(st[6]), .i_wake_frame(st[5]), .i_link_pass(st[4]),
      .i_full_duplex(st[3]), .i_matched_rx(st[2]), .i_rx_activity(st[1]),
      .i_collision(st[0]), .o_led_out, .o_led_oe_n);
   sldrv_led_model u_sldrv_led_model (.i_led_out(o_led_out),
      .i_led_oe_n(o_led_oe_n), .o_pin(pin));
   task automatic test_done;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_sys_clk);
      i_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_sys_clk);
      i_rd   <= 1'b0;
      #1;
      compares++;
      if (o_rdata !== e) begin
         num_errors++;
         $display("BAD rdata exp %h got %h", e, o_rdata);
      end
   endtask
   task automatic cmp1(input logic e);
      #1;
      compares++;
      if (pin !== e) begin
         num_errors++;
         $display("BAD pin exp %b got %b", e, pin);
      end
   endtask
   // Same indicator seen as totem pole, then as open drain
   task automatic cond(input logic [15:0] m, input logic [7:0] s,
                       input logic e);
      wr(4'h0, {16'h0, 16'h4000 | m});
      st <= s;
      tick(5);
      rd(4'h0, {16'h0, e, 15'h4000 | m[14:0]});
      cmp1(e);
      wr(4'h0, {16'h0, m});
      tick(3);
      st <= 8'h0;
      cmp1(!e);
   endtask
   // One-cycle event; only the stretcher can keep it visible
   task automatic pulse(input logic e);
      tick(6);
      st <= 8'h01;
      tick(1);
      st <= 8'h00;
      tick(5);
      cmp1(e);
   endtask
   initial begin
      #300000;
      num_errors++;
      test_done;
   end
   initial begin
      tick(8);
      i_nrst <= 1'b1;
      rd(4'h0, 32'h80);
      wr(4'h0, 32'h4041);
      rd(4'h0, 32'h80);
      wr(4'h4, 32'h1000);
      wr(4'h0, 32'hffff_ffff);
      rd(4'h0, 32'h73e5);
      rd(4'h8, 32'h0);
      cond(16'h1000, 8'h80, 1'b1);
      cond(16'h0200, 8'h60, 1'b1);
      cond(16'h0200, 8'h20, 1'b0);
      cond(16'h0100, 8'h18, 1'b1);
      cond(16'h0100, 8'h10, 1'b0);
      cond(16'h0040, 8'h10, 1'b1);
      cond(16'h0020, 8'h04, 1'b1);
      cond(16'h0004, 8'h02, 1'b1);
      cond(16'h0001, 8'h01, 1'b1);
      cond(16'h0000, 8'hff, 1'b0);
      wr(4'h0, 32'h2001);
      st <= 8'h01;
      tick(5);
      cmp1(1'b1);
      rd(4'h0, 32'ha001);
      wr(4'h0, 32'h0081);
      st <= 8'h00;
      pulse(1'b0);
      tick(14);
      cmp1(1'b1);
      wr(4'h0, 32'h0001);
      pulse(1'b1);
      tick(1);
      i_nrst <= 1'b0;
      tick(2);
      i_nrst <= 1'b1;
      rd(4'h0, 32'h80);
      rd(4'h4, 32'h0);
      test_done;
   end
endmodule // sldrv_top_test
`default_nettype wire
